// *** include/mfp_pkg.sv ***
/*
  Constants, register map, flag layout and carrier types for the motor fault protection block.
  Assumes a 250 MHz system clock and a classic Wishbone register slave with 32-bit data.
*/
package mfp_pkg;

  // Timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned NO_MOTOR_MS = 500;
  localparam int unsigned NO_MOTOR_CYC = (CLK_HZ / 1000) * NO_MOTOR_MS;
  localparam int unsigned RETRY_UNIT_CYC = CLK_HZ / 1000;
  localparam int unsigned PROBE_HZ0 = 10_000_000;
  localparam int unsigned PROBE_HZ1 = 1_000_000;
  localparam int unsigned PROBE_HZ2 = 100_000;
  localparam int unsigned PROBE_HZ3 = 10_000;
  localparam int unsigned PROBE_DIV0 = CLK_HZ / PROBE_HZ0;
  localparam int unsigned PROBE_DIV1 = CLK_HZ / PROBE_HZ1;
  localparam int unsigned PROBE_DIV2 = CLK_HZ / PROBE_HZ2;
  localparam int unsigned PROBE_DIV3 = CLK_HZ / PROBE_HZ3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_THR_LOCK = 8'h08;
  localparam logic [7:0] OFS_THR_MEAS = 8'h0c;
  localparam logic [7:0] OFS_THR_PROBE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;

  // Field positions and codes
  localparam int unsigned CTRL_CLR_BIT = 0;
  localparam logic [1:0] STARTUP_PROBE = 2'h2;
  localparam logic [3:0] MODE_REPORT = 4'h8;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Flag positions in the status register
  localparam int unsigned F_DRV = 0;
  localparam int unsigned F_OT = 1;
  localparam int unsigned F_OTS = 2;
  localparam int unsigned F_CTRL = 3;
  localparam int unsigned F_LOCK = 4;
  localparam int unsigned F_OSPD = 5;
  localparam int unsigned F_BEMF = 6;
  localparam int unsigned F_NOLD = 7;
  localparam int unsigned F_MPOS = 8;
  localparam int unsigned F_MBEMF = 9;
  localparam int unsigned F_RAMP = 10;
  localparam int unsigned F_DECAY = 11;
  localparam int unsigned F_RATE = 12;
  localparam int unsigned NFLAG = 13;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mfp_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } mfp_wb_rsp_t;

  // Measurements and algorithm strobes from the motor controller
  typedef struct packed {
    logic temp_over_limit;
    logic temp_below_hys;
    logic regulator_overheat;
    logic motor_running;
    logic [15:0] speed;
    logic [15:0] bemf_est;
    logic [15:0] bemf_exp;
    logic [2:0][11:0] phase_curr;
    logic [11:0] probe_curr;
    logic probe_pulse_cmd;
    logic probe_done;
    logic measure_rl_active;
    logic measure_bemf_valid;
    logic [15:0] measure_bemf;
  } mfp_sense_t;

  typedef struct packed {
    logic [2:0] hs_on;
    logic [2:0] ls_on;
    logic hiz;
    logic pump_en;
  } mfp_gate_t;

  typedef enum logic [2:0] {
    LCK_IDLE = 3'b001,
    LCK_LATCH = 3'b010,
    LOCK_RETRY_TIME = 3'b100
  } mfp_lock_st_t;

  typedef enum logic [4:0] {
    PRB_IDLE = 5'b00001,
    PRB_RAMP = 5'b00010,
    PRB_DECAY = 5'b00100,
    PRB_GAP = 5'b01000,
    PRB_RETRY = 5'b10000
  } mfp_probe_st_t;

endpackage

// *** hdl/mfp_top.sv ***
/*
  Motor fault protection: thermal shutdown, motor lock response, lock detection,
  parameter measurement faults and position probe timing, with a Wishbone register slave.
  Assumes all inputs synchronous to clk_i and an external open-drain fault wire.
*/
`timescale 1ns/1ps
module mfp_top #(
  parameter int unsigned NO_MOTOR_CYC = mfp_pkg::NO_MOTOR_CYC,
  parameter int unsigned RETRY_UNIT_CYC = mfp_pkg::RETRY_UNIT_CYC,
  parameter int unsigned PROBE_DIV3 = mfp_pkg::PROBE_DIV3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire mfp_pkg::mfp_wb_req_t wb_req_i,
  output mfp_pkg::mfp_wb_rsp_t wb_rsp_o,
  // Controller side
  input wire mfp_pkg::mfp_sense_t sense_i,
  input wire mfp_pkg::mfp_gate_t gate_req_i,
  // Power stage
  output mfp_pkg::mfp_gate_t gate_o,
  output logic probe_rerun_o,
  output logic startup_retry_o,
  // Open-drain fault pin
  input wire logic fault_pin_i,
  output logic fault_pin_n_o,
  output logic fault_pin_oe_o
);
  import mfp_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [31:0] cfg;
    logic [31:0] thr_lock;
    logic [31:0] thr_meas;
    logic [31:0] thr_probe;
    logic clr;
    logic [NFLAG-1:0] flags;
    logic tsd;
    mfp_lock_st_t lst;
    logic [1:0] lact;
    logic [15:0] lms;
    logic [31:0] unit_cnt;
    logic [31:0] nm_cnt;
    mfp_probe_st_t pst;
    logic [1:0] prate;
    logic [11:0] ptmr;
    logic [31:0] pdiv;
    logic pmeas;
    logic [15:0] pms;
    logic rerun;
    logic retry;
    mfp_gate_t gate;
    logic fault_n;
    logic pin_seen;
  } mfp_state_t;

  mfp_state_t st_q;
  mfp_state_t st_d;

  // Configuration fields
  logic [3:0] lock_response_mode;
  logic overspeed_detect_enable;
  logic bemf_check_enable;
  logic no_motor_detect_enable;
  logic [1:0] startup_method;
  logic position_probe_timeout_enable;
  logic position_probe_rate_fault_enable;
  logic [15:0] lock_retry_time;
  assign lock_response_mode = st_q.cfg[3:0];
  assign overspeed_detect_enable = st_q.cfg[4];
  assign bemf_check_enable = st_q.cfg[5];
  assign no_motor_detect_enable = st_q.cfg[6];
  assign startup_method = st_q.cfg[8:7];
  assign position_probe_timeout_enable = st_q.cfg[9];
  assign position_probe_rate_fault_enable = st_q.cfg[10];
  assign lock_retry_time = st_q.cfg[31:16];

  // Mode classes
  logic mode_latch;
  logic mode_auto;
  logic mode_off;
  assign mode_latch = lock_response_mode[3:2] == 2'h0;
  assign mode_auto = lock_response_mode[3:2] == 2'h1;
  assign mode_off = lock_response_mode[3] & lock_response_mode[0];

  // Per-phase absent-load comparison
  logic [2:0] phase_low;
  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_phase
      assign phase_low[p] = sense_i.phase_curr[p] < st_q.thr_meas[11:0];
    end
  endgenerate

  // Lock causes
  logic [15:0] bemf_gap;
  logic [2:0] cause;
  logic lock_cond;
  assign bemf_gap = (sense_i.bemf_est > sense_i.bemf_exp) ? sense_i.bemf_est - sense_i.bemf_exp
                                                          : sense_i.bemf_exp - sense_i.bemf_est;
  assign cause[0] = overspeed_detect_enable & sense_i.motor_running
                    & (sense_i.speed > st_q.thr_lock[15:0]);
  assign cause[1] = bemf_check_enable & sense_i.motor_running
                    & (bemf_gap > st_q.thr_lock[31:16]);
  assign cause[2] = no_motor_detect_enable & (st_q.nm_cnt >= NO_MOTOR_CYC);
  assign lock_cond = |cause;

  // Probe clock divider for the current rate
  function automatic logic [31:0] probe_div(input logic [1:0] rate);
    case (rate)
      2'h0: probe_div = 32'(PROBE_DIV0);
      2'h1: probe_div = 32'(PROBE_DIV1);
      2'h2: probe_div = 32'(PROBE_DIV2);
      default: probe_div = 32'(PROBE_DIV3);
    endcase
  endfunction

  // Byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic req;
  logic wr;
  logic ms_tick;
  logic ptick;
  logic povf;
  assign req = wb_req_i.cyc & wb_req_i.stb;
  assign wr = req & wb_req_i.we & st_q.ack;
  assign ms_tick = st_q.unit_cnt == RETRY_UNIT_CYC - 1;
  assign ptick = st_q.pdiv == probe_div(st_q.prate) - 32'h1;
  assign povf = ptick & (st_q.ptmr == 12'hfff);

  // Next-state logic
  always_comb
  begin
    logic [NFLAG-1:0] set;
    logic [NFLAG-1:0] keep;
    logic [NFLAG-1:0] drop;
    logic lock_evt;
    logic pfault;
    set = '0;
    keep = '0;
    drop = '0;
    pfault = 1'b0;
    st_d = st_q;
    st_d.rerun = 1'b0;
    st_d.retry = 1'b0;
    st_d.pin_seen = fault_pin_i;
    // Bus slave, one wait state
    st_d.ack = req & ~st_q.ack;
    st_d.clr = 1'b0;
    case (wb_req_i.adr)
      OFS_CFG: st_d.rdat = st_q.cfg;
      OFS_THR_LOCK: st_d.rdat = st_q.thr_lock;
      OFS_THR_MEAS: st_d.rdat = st_q.thr_meas;
      OFS_THR_PROBE: st_d.rdat = st_q.thr_probe;
      OFS_STATUS: st_d.rdat = 32'(st_q.flags);
      OFS_STATE: st_d.rdat = {20'h0, st_q.pin_seen, st_q.prate, st_q.pst, st_q.lst, st_q.tsd};
      default: st_d.rdat = 32'h0;
    endcase
    if (wr)
    begin
      case (wb_req_i.adr)
        OFS_CTRL: st_d.clr = wb_req_i.sel[0] & wb_req_i.dat[CTRL_CLR_BIT];
        OFS_CFG: st_d.cfg = merge(st_q.cfg, wb_req_i.dat, wb_req_i.sel);
        OFS_THR_LOCK: st_d.thr_lock = merge(st_q.thr_lock, wb_req_i.dat, wb_req_i.sel);
        OFS_THR_MEAS: st_d.thr_meas = merge(st_q.thr_meas, wb_req_i.dat, wb_req_i.sel);
        OFS_THR_PROBE: st_d.thr_probe = merge(st_q.thr_probe, wb_req_i.dat, wb_req_i.sel);
        default: st_d.rdat = st_d.rdat;
      endcase
    end
    // Millisecond time base
    st_d.unit_cnt = ms_tick ? 32'h0 : st_q.unit_cnt + 32'h1;
    // Absent-load timer: any phase low, held continuously
    if (|phase_low)
    begin
      st_d.nm_cnt = (st_q.nm_cnt >= NO_MOTOR_CYC) ? st_q.nm_cnt : st_q.nm_cnt + 32'h1;
    end
    else
    begin
      st_d.nm_cnt = 32'h0;
    end
    // Thermal shutdown, no enable exists
    if (sense_i.temp_over_limit)
    begin
      st_d.tsd = 1'b1;
      set[F_DRV] = 1'b1;
      set[F_OT] = 1'b1;
      set[F_OTS] = 1'b1;
    end
    else if (sense_i.temp_below_hys)
    begin
      st_d.tsd = 1'b0;
    end
    keep[F_DRV] = st_q.tsd;
    keep[F_OT] = st_q.tsd;
    keep[F_OTS] = st_q.tsd;
    // Motor lock response
    lock_evt = lock_cond & ~mode_off & (st_q.lst == LCK_IDLE);
    if (lock_evt)
    begin
      set[F_CTRL] = 1'b1;
      set[F_LOCK] = 1'b1;
      set[F_NOLD:F_OSPD] = cause;
    end
    keep[F_CTRL] = lock_cond | (st_q.lst == LOCK_RETRY_TIME);
    keep[F_LOCK] = keep[F_CTRL];
    keep[F_NOLD:F_OSPD] = cause | {3{st_q.lst == LOCK_RETRY_TIME}};
    case (st_q.lst)
      LCK_IDLE:
      begin
        st_d.lms = 16'h0;
        st_d.lact = lock_response_mode[1:0];
        if (lock_evt & mode_latch)
        begin
          st_d.lst = LCK_LATCH;
        end
        else if (lock_evt & mode_auto)
        begin
          st_d.lst = LOCK_RETRY_TIME;
        end
      end
      LCK_LATCH:
      begin
        if (st_q.clr & ~lock_cond)
        begin
          st_d.lst = LCK_IDLE;
        end
      end
      LOCK_RETRY_TIME:
      begin
        if (st_q.lms >= lock_retry_time)
        begin
          st_d.lst = LCK_IDLE;
          drop[F_CTRL] = 1'b1;
          drop[F_LOCK] = 1'b1;
          drop[F_NOLD:F_OSPD] = 3'h7;
        end
        else if (ms_tick)
        begin
          st_d.lms = st_q.lms + 16'h1;
        end
      end
      default: st_d.lst = LCK_IDLE;
    endcase
    // Parameter measurement back-EMF check
    if (sense_i.measure_bemf_valid & (sense_i.measure_bemf < st_q.thr_meas[31:16]))
    begin
      set[F_MBEMF] = 1'b1;
    end
    // Position probe timing
    st_d.pdiv = ptick ? 32'h0 : st_q.pdiv + 32'h1;
    if (ptick)
    begin
      st_d.ptmr = st_q.ptmr + 12'h1;
    end
    case (st_q.pst)
      PRB_IDLE, PRB_GAP:
      begin
        st_d.pms = 16'h0;
        if (sense_i.probe_done)
        begin
          st_d.pst = PRB_IDLE;
        end
        else if (sense_i.probe_pulse_cmd
                 & ((startup_method == STARTUP_PROBE) | sense_i.measure_rl_active))
        begin
          st_d.pst = PRB_RAMP;
          st_d.pmeas = sense_i.measure_rl_active;
          st_d.prate = 2'h0;
          st_d.ptmr = 12'h0;
          st_d.pdiv = 32'h0;
        end
      end
      PRB_RAMP, PRB_DECAY:
      begin
        if ((st_q.pst == PRB_DECAY) & sense_i.probe_pulse_cmd & position_probe_rate_fault_enable)
        begin
          set[F_RATE] = 1'b1;
          pfault = 1'b1;
        end
        else if ((st_q.pst == PRB_RAMP) ? (sense_i.probe_curr >= st_q.thr_probe[11:0])
                                         : (sense_i.probe_curr == 12'h0))
        begin
          st_d.pst = (st_q.pst == PRB_RAMP) ? PRB_DECAY : PRB_GAP;
          st_d.prate = 2'h0;
          st_d.ptmr = 12'h0;
          st_d.pdiv = 32'h0;
        end
        else if (povf & (st_q.prate != 2'h3))
        begin
          st_d.prate = st_q.prate + 2'h1;
          st_d.ptmr = 12'h0;
          st_d.rerun = 1'b1;
        end
        else if (povf & st_q.pmeas)
        begin
          set[F_MPOS] = 1'b1;
          st_d.pst = PRB_IDLE;
        end
        else if (povf & position_probe_timeout_enable)
        begin
          set[F_RAMP] = st_q.pst == PRB_RAMP;
          set[F_DECAY] = st_q.pst == PRB_DECAY;
          pfault = 1'b1;
        end
        else if (povf)
        begin
          st_d.pst = PRB_GAP;
        end
        if (pfault)
        begin
          st_d.pst = PRB_RETRY;
        end
      end
      PRB_RETRY:
      begin
        if (st_q.pms >= lock_retry_time)
        begin
          st_d.pst = PRB_IDLE;
          st_d.retry = 1'b1;
        end
        else if (ms_tick)
        begin
          st_d.pms = st_q.pms + 16'h1;
        end
      end
      default: st_d.pst = PRB_IDLE;
    endcase
    // Flags: set wins, clear spares present conditions
    st_d.flags = set | (st_q.flags & ~(({NFLAG{st_q.clr}} & ~keep) | drop));
    // Bridge and fault pin from the next state
    st_d.gate = gate_req_i;
    st_d.gate.hiz = 1'b0;
    st_d.gate.pump_en = 1'b1;
    st_d.fault_n = 1'b1;
    if (st_d.tsd)
    begin
      st_d.gate = '0;
      st_d.fault_n = 1'b0;
      st_d.gate.hiz = 1'b1;
    end
    else if (st_d.lst != LCK_IDLE)
    begin
      st_d.fault_n = 1'b0;
      st_d.gate.hs_on = (st_d.lact == 2'h2) ? 3'h7 : 3'h0;
      st_d.gate.ls_on = (st_d.lact == 2'h3) ? 3'h7 : 3'h0;
      st_d.gate.hiz = ~st_d.lact[1];
    end
    else if (st_d.pst == PRB_RETRY)
    begin
      st_d.gate.hs_on = 3'h0;
      st_d.gate.ls_on = 3'h0;
      st_d.gate.hiz = 1'b1;
    end
  end

  // State register; regulator overheat acts as a full reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i | sense_i.regulator_overheat)
    begin
      st_q <= '{lst: LCK_IDLE, pst: PRB_IDLE, fault_n: 1'b1, pin_seen: 1'b1, cfg: CFG_RESET,
               default: '0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs
  assign wb_rsp_o.ack = st_q.ack;
  assign wb_rsp_o.dat = st_q.rdat;
  assign gate_o = st_q.gate;
  assign probe_rerun_o = st_q.rerun;
  assign startup_retry_o = st_q.retry;
  assign fault_pin_n_o = 1'b0;
  assign fault_pin_oe_o = ~st_q.fault_n;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i | sense_i.regulator_overheat);

  a_tsd_pin_low: assert property (sense_i.temp_over_limit |=> fault_pin_oe_o && !gate_o.pump_en && gate_o.hs_on == 3'h0) else $error("thermal shutdown not applied");
  a_tsd_flags_set: assert property (sense_i.temp_over_limit |=> st_q.flags[F_DRV] && st_q.flags[F_OT] && st_q.flags[F_OTS]) else $error("thermal flags missing");
  a_ots_sticky_hold: assert property (st_q.flags[F_OTS] && !st_q.clr |=> st_q.flags[F_OTS]) else $error("shutdown flag lost");
  a_latch_hold_on: assert property (st_q.lst == LCK_LATCH && !st_q.clr |=> st_q.lst == LCK_LATCH && fault_pin_oe_o) else $error("latched lock released");
  a_latch_hs_on: assert property (st_q.lst == LCK_LATCH && st_q.lact == 2'h2 && !st_q.tsd |-> gate_o.hs_on == 3'h7 && gate_o.ls_on == 3'h0) else $error("high-side state wrong");
  a_disabled_no_flag: assert property (mode_off && !st_q.flags[F_CTRL] && st_q.lst == LCK_IDLE |=> !st_q.flags[F_CTRL]) else $error("disabled mode flagged");
  a_report_runs_on: assert property (lock_response_mode == MODE_REPORT && st_q.lst == LCK_IDLE && !sense_i.temp_over_limit |=> st_q.lst == LCK_IDLE) else $error("report mode acted");
  a_probe_retry_hiz: assert property (st_q.pst == PRB_RETRY && !st_q.tsd && st_q.lst == LCK_IDLE |-> gate_o.hiz && gate_o.ls_on == 3'h0) else $error("probe fault not Hi-Z");
  a_rate_fault_set: assert property (st_q.pst == PRB_DECAY && sense_i.probe_pulse_cmd && position_probe_rate_fault_enable |=> st_q.flags[F_RATE] && st_q.pst == PRB_RETRY) else $error("rate fault missed");
  a_clear_one_cycle: assert property (st_q.clr |=> !st_q.clr) else $error("clear not a pulse");
  a_ack_single: assert property (st_q.ack |=> !st_q.ack) else $error("ack held");

  c_tsd: cover property (st_q.tsd ##1 !st_q.tsd);
  c_latch_clear: cover property (st_q.lst == LCK_LATCH ##1 st_q.lst == LCK_IDLE);
  c_auto_retry: cover property (st_q.lst == LOCK_RETRY_TIME ##1 st_q.lst == LCK_IDLE);
  c_probe_fault: cover property (st_q.pst == PRB_RETRY ##1 startup_retry_o);

endmodule // mfp_top

// *** bench/mfp_stage_model.sv ***
/*
  Power stage side of the fault wire for the fault protection bench.
  Assumes the block pulls the open-drain wire low while its enable is high.
*/
`timescale 1ns/1ps
module mfp_stage_model (
  // Block side of the open-drain pin
  input wire logic fault_pin_n_i,
  input wire logic fault_pin_oe_i,
  // Resolved wire level
  output logic fault_wire_o
);
  // Pull-up holds the wire high unless the block drives it
  assign fault_wire_o = fault_pin_oe_i ? fault_pin_n_i : 1'b1;
endmodule // mfp_stage_model

// *** bench/testbench.sv ***
/*
  Self-checking bench for the motor fault protection block.
  Assumes shortened counts: 20 cycle absent-load window, 10 cycles per retry ms.
*/
`timescale 1ns/1ps
module testbench;
  import mfp_pkg::*;
  localparam int unsigned NMC = 20;
  localparam int unsigned RUC = 10;
  localparam logic [31:0] TH = 32'h7;
  localparam logic [31:0] LK = 32'h38;
  localparam logic [31:0] LB = 32'h58;
  localparam logic [31:0] AB = 32'h98;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  mfp_wb_req_t req = '0;
  mfp_wb_rsp_t rsp;
  mfp_sense_t sense = '0;
  mfp_gate_t gate_req = '{3'h5, 3'h2, 1'b0, 1'b0};
  mfp_gate_t gate;
  logic wire_lvl;
  logic pin_n;
  logic pin_oe;
  logic [31:0] rd;
  int failures = 0;
  int samples_checked = 0;

  // Clock at 250 MHz
  always #2 clk_i = ~clk_i;

  mfp_top #(.NO_MOTOR_CYC(NMC), .RETRY_UNIT_CYC(RUC), .PROBE_DIV3(300)) i_mfp_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .sense_i(sense),
    .gate_req_i(gate_req), .gate_o(gate), .probe_rerun_o(), .startup_retry_o(),
    .fault_pin_i(wire_lvl), .fault_pin_n_o(pin_n), .fault_pin_oe_o(pin_oe));

  mfp_stage_model i_mfp_stage_model (
    .fault_pin_n_i(pin_n), .fault_pin_oe_i(pin_oe), .fault_wire_o(wire_lvl));

  task automatic summarize;
    $display("Checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      failures++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic cycle; ack sampled at rising edges, released at the ack edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    @(posedge clk_i);
    while (rsp.ack !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        failures++;
        summarize();
      end
      @(posedge clk_i);
    end
    rd = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  task automatic st(input logic [31:0] e, input string m);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, e, m);
  endtask

  task automatic clr;
    wb(1'b1, OFS_CTRL, 32'h1);
    cyc(2);
  endtask

  // Bridge state and fault wire at mid cycle
  task automatic gchk(input logic [2:0] hs, input logic [2:0] ls, input logic oe,
                      input string m);
    @(negedge clk_i);
    chk({26'h0, gate.hs_on, gate.ls_on}, {26'h0, hs, ls}, m);
    chk({31'h0, pin_oe}, {31'h0, oe}, m);
    chk({31'h0, wire_lvl}, {31'h0, ~oe}, m);
  endtask

  task automatic t_reset;
    wb(1'b0, OFS_CFG, 32'h0);
    chk(rd, CFG_RESET, "cfg reset");
    wb(1'b1, OFS_STATUS, 32'hffff_ffff);
    st(32'h0, "status read-only");
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("reset test done");
  endtask

  task automatic t_thermal;
    gchk(3'h5, 3'h2, 1'b0, "normal drive");
    sense.temp_below_hys <= 1'b0;
    sense.temp_over_limit <= 1'b1;
    cyc(2);
    gchk(3'h0, 3'h0, 1'b1, "shutdown gates");
    chk({31'h0, gate.pump_en}, 32'h0, "pump off");
    wb(1'b1, OFS_CFG, 32'hffff_ffff);
    gchk(3'h0, 3'h0, 1'b1, "no disable");
    clr();
    st(TH, "flags while hot");
    sense.temp_over_limit <= 1'b0;
    sense.temp_below_hys <= 1'b1;
    cyc(2);
    gchk(3'h5, 3'h2, 1'b0, "resume when cool");
    st(TH, "shutdown flag sticky");
    clr();
    st(32'h0, "thermal cleared");
    wb(1'b1, OFS_CFG, 32'h0);
    $display("thermal test done");
  endtask

  // Overspeed lock under a latched or auto-recovery mode
  task automatic t_lock(input logic [3:0] m);
    logic [2:0] hs;
    logic [2:0] ls;
    hs = (m[1:0] == 2'h2) ? 3'h7 : 3'h0;
    ls = (m[1:0] == 2'h3) ? 3'h7 : 3'h0;
    wb(1'b1, OFS_THR_LOCK, 32'h0010_0100);
    wb(1'b1, OFS_CFG, 32'h0002_0010 | {28'h0, m});
    sense.motor_running <= 1'b1;
    sense.speed <= 16'h0200;
    cyc(2);
    gchk(hs, ls, 1'b1, "lock forced");
    sense.speed <= 16'h0000;
    st(LK, "lock flags");
    gchk(hs, ls, 1'b1, "lock held");
    if (m[2] == 1'b0)
    begin
      cyc(4 * RUC);
      gchk(hs, ls, 1'b1, "latched without clear");
      clr();
    end
    else
      cyc(4 * RUC);
    gchk(3'h5, 3'h2, 1'b0, "lock resumed");
    st(32'h0, "lock flags clear");
    $display("lock mode %h done", m);
  endtask

  // Back-EMF lock under report-only or disabled mode, overspeed not enabled
  task automatic t_report(input logic [3:0] m, input logic [31:0] e);
    wb(1'b1, OFS_CFG, 32'h0000_0020 | {28'h0, m});
    sense.speed <= 16'h0200;
    sense.bemf_est <= 16'h0100;
    cyc(2);
    gchk(3'h5, 3'h2, 1'b0, "drivers run");
    st(e, "report flags");
    clr();
    st(e, "kept while present");
    sense.speed <= 16'h0000;
    sense.bemf_est <= 16'h0000;
    clr();
    st(32'h0, "report cleared");
    $display("report mode %h done", m);
  endtask

  task automatic t_absent;
    wb(1'b1, OFS_THR_MEAS, 32'h0000_0100);
    sense.phase_curr <= {3{12'h200}};
    wb(1'b1, OFS_CFG, 32'h0000_0048);
    sense.phase_curr[1] <= 12'h010;
    cyc(NMC - 8);
    st(32'h0, "absent load early");
    cyc(NMC);
    st(AB, "absent load event");
    sense.phase_curr <= {3{12'h200}};
    clr();
    st(32'h0, "absent load cleared");
    $display("absent load test done");
  endtask

  // Second probe pulse while the first still decays
  task automatic t_probe;
    wb(1'b1, OFS_THR_PROBE, 32'h0000_0100);
    wb(1'b1, OFS_CFG, 32'h0000_0500);
    sense.probe_curr <= 12'h200;
    sense.probe_pulse_cmd <= 1'b1;
    cyc(1);
    sense.probe_pulse_cmd <= 1'b0;
    cyc(2);
    sense.probe_pulse_cmd <= 1'b1;
    cyc(1);
    sense.probe_pulse_cmd <= 1'b0;
    sense.probe_curr <= 12'h000;
    cyc(2);
    st(32'h0000_1000, "probe rate fault");
    clr();
    st(32'h0, "probe fault cleared");
    wb(1'b1, OFS_CFG, 32'h0);
    $display("probe test done");
  endtask

  task automatic t_regulator;
    wb(1'b1, OFS_CFG, 32'h0000_0010);
    sense.speed <= 16'h0200;
    cyc(2);
    sense.speed <= 16'h0000;
    sense.regulator_overheat <= 1'b1;
    cyc(2);
    sense.regulator_overheat <= 1'b0;
    cyc(2);
    st(32'h0, "overheat reset flags");
    gchk(3'h5, 3'h2, 1'b0, "overheat reset gates");
    $display("regulator test done");
  endtask

  // Main sequence
  initial
  begin
    sense.temp_below_hys = 1'b1;
    cyc(3);
    rst_i <= 1'b0;
    cyc(2);
    t_reset();
    t_thermal();
    for (int k = 0; k < 8; k++)
      t_lock(4'(k));
    t_report(MODE_REPORT, LB);
    t_report(4'h9, 32'h0);
    t_absent();
    t_probe();
    t_regulator();
    summarize();
  end

  // Hang guard
  initial
  begin
    cyc(20000);
    failures++;
    summarize();
  end
endmodule // testbench
